/* File: core/adss_top.sv */
`timescale 1ns/1ps
module adss_top
    import adss_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rd_data,
    input  wire logic                cmp_in,
    input  wire logic [CHAN_N-1:0]   pull_up_req,
    input  wire logic [CHAN_N-1:0]   port_oe_req,
    output logic                     conv_power,
    output logic                     bandgap_enable,
    output adss_ref_t                ref_kind,
    output logic                     ext_ref_pin_en,
    output logic                     amp_bandgap_in,
    output logic                     amp_ext_pin_en,
    output logic      [1:0]          amp_gain,
    output adss_in_t                 in_kind,
    output logic                     ext_chan_en,
    output logic      [3:0]          ext_chan,
    output logic                     sample_on,
    output logic      [RES_W-1:0]    dac_code,
    output logic                     conv_busy,
    output logic                     irq,
    output logic      [CHAN_N-1:0]   pin_analog,
    output logic      [CHAN_N-1:0]   pull_up_en,
    output logic      [CHAN_N-1:0]   port_oe
);
    logic [DATA_W-1:0] rd_data_ff;
    logic              start_ff;
    logic              start_prev_ff;
    logic              pwr_ff;
    logic              fmt_ff;
    logic [3:0]        chan_ff;
    logic [3:0]        src_ff;
    logic [2:0]        div_ff;
    logic              ampin_ff;
    logic [1:0]        ref_ff;
    logic [1:0]        gain_ff;
    logic              bgap_ff;
    logic              gie_ff;
    logic              cie_ff;
    logic              flag_ff;
    logic              irq_ff;
    logic [CHAN_N-1:0] pin_ana_ff;
    logic [CHAN_N-1:0] pull_up_ff;
    logic [CHAN_N-1:0] port_oe_ff;
    logic [RES_W-1:0]  result_ff;
    logic [RES_W-1:0]  sar_ff;
    logic              busy_ff;
    adss_state_t       state_ff;
    logic [3:0]        cnt_ff;
    logic              sample_ff;
    logic              cmp_meta_ff;
    logic              cmp_ff;
    adss_ref_t         ref_kind_ff;
    logic              ext_ref_ff;
    logic              amp_bg_ff;
    logic              amp_ext_ff;
    adss_in_t          in_kind_ff;
    logic              ext_en_ff;
    logic [3:0]        ext_chan_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic [RES_W-1:0]  nxt_sar;
    adss_ref_t         sel_ref;
    adss_in_t          sel_in;
    logic              sel_ext_ref;
    logic              sel_amp_bg;
    logic              sel_amp_ext;
    logic              sel_ext_en;
    logic              tick;
    logic              start_rise;
    logic              start_fall;
    logic              launch;
    logic              conv_done;

    function automatic logic [RES_W-1:0] sar_step(input logic [RES_W-1:0] code,
                                                  input logic [3:0]       step,
                                                  input logic             keep);
        logic [3:0] idx;
        logic [RES_W-1:0] r;
        idx = 4'(RES_W - 1) - step;
        r = code;
        if (!keep) begin
            r[idx] = 1'b0;
        end
        if (idx != 4'h0) begin
            r[idx - 4'h1] = 1'b1;
        end
        return r;
    endfunction

    wire wr_c0 = wr_en && (addr == ADDR_CTRL0);
    wire wr_c1 = wr_en && (addr == ADDR_CTRL1);
    wire wr_c2 = wr_en && (addr == ADDR_CTRL2);

    // control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_ff <= BIT_RST;
            pwr_ff   <= BIT_RST;
            fmt_ff   <= BIT_RST;
            chan_ff  <= REG_RST[3:0];
            src_ff   <= REG_RST[3:0];
            div_ff   <= REG_RST[2:0];
            ampin_ff <= BIT_RST;
            ref_ff   <= REG_RST[1:0];
            gain_ff  <= REG_RST[1:0];
        end else begin
            if (wr_c0) begin
                start_ff <= wr_data[C0_START];
                pwr_ff   <= wr_data[C0_PWR];
                fmt_ff   <= wr_data[C0_FMT];
                chan_ff  <= wr_data[C0_CHAN_LSB +: 4];
            end
            if (wr_c1) begin
                src_ff <= wr_data[C1_SRC_LSB +: 4];
                div_ff <= wr_data[C1_DIV_LSB +: 3];
            end
            if (wr_c2) begin
                ampin_ff <= wr_data[C2_AMPIN];
                ref_ff   <= wr_data[C2_REF_LSB +: 2];
                gain_ff  <= wr_data[C2_GAIN_LSB +: 2];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bgap_ff <= BIT_RST;
        end else if (wr_en && (addr == ADDR_BGAP)) begin
            bgap_ff <= wr_data[BG_EN];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ana_ff <= '0;
        end else if (wr_en && (addr == ADDR_PIN_LO)) begin
            pin_ana_ff[7:0] <= wr_data;
        end else if (wr_en && (addr == ADDR_PIN_HI)) begin
            pin_ana_ff[15:8] <= wr_data;
        end
    end

    // start bit edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_ff <= BIT_RST;
        end else begin
            start_prev_ff <= start_ff;
        end
    end

    assign start_rise = start_ff && !start_prev_ff;
    assign start_fall = !start_ff && start_prev_ff;
    assign launch     = start_fall && pwr_ff;

    adss_clk_div #(
        .SEL_W (3),
        .CNT_W (7)
    ) u_div (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .restart (launch),
        .div_sel (div_ff),
        .tick    (tick)
    );

    assign conv_done = tick && (state_ff == ST_CONVERT) && (cnt_ff == CONV_CLKS - 4'h1)
                       && !start_rise && !launch && pwr_ff;

    // comparator from the analog core crosses into this domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_ff <= BIT_RST;
            cmp_ff      <= BIT_RST;
        end else begin
            cmp_meta_ff <= cmp_in;
            cmp_ff      <= cmp_meta_ff;
        end
    end

    assign nxt_sar = sar_step(sar_ff, cnt_ff, cmp_ff);

    // sequencer, steps on converter ticks; a start rise or power-off aborts it and a launch restarts it at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            busy_ff  <= BIT_RST;
            cnt_ff   <= '0;
            sar_ff   <= RES_RST;
        end else if (start_rise || !pwr_ff) begin
            state_ff <= ST_IDLE;
            busy_ff  <= BIT_RST;
            cnt_ff   <= '0;
        end else if (launch) begin
            state_ff <= ST_SAMPLE;
            busy_ff  <= 1'b1;
            cnt_ff   <= '0;
        end else if (tick) begin
            unique case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= '0;
                end
                ST_SAMPLE: begin
                    if (cnt_ff == SAMPLE_CLKS - 4'h1) begin
                        state_ff <= ST_CONVERT;
                        cnt_ff   <= '0;
                        sar_ff   <= SAR_INIT;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                ST_CONVERT: begin
                    sar_ff <= nxt_sar;
                    if (cnt_ff == CONV_CLKS - 4'h1) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= BIT_RST;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= RES_RST;
        end else if (conv_done) begin
            result_ff <= nxt_sar;
        end
    end

    // a completion in the clearing cycle keeps the flag set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gie_ff  <= BIT_RST;
            cie_ff  <= BIT_RST;
            flag_ff <= BIT_RST;
        end else begin
            if (wr_en && (addr == ADDR_IRQ)) begin
                gie_ff <= wr_data[IRQ_GIE];
                cie_ff <= wr_data[IRQ_CIE];
            end
            if (conv_done) begin
                flag_ff <= 1'b1;
            end else if (wr_en && (addr == ADDR_IRQ)) begin
                flag_ff <= wr_data[IRQ_FLAG];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= BIT_RST;
        end else begin
            irq_ff <= flag_ff && gie_ff && cie_ff;
        end
    end

    always_comb begin
        nxt_rd_data = '0;
        unique case (addr)
            ADDR_CTRL0: begin
                nxt_rd_data = {start_ff, busy_ff, pwr_ff, fmt_ff, chan_ff};
            end
            ADDR_CTRL1:  nxt_rd_data = {src_ff, 1'b0, div_ff};
            ADDR_CTRL2:  nxt_rd_data = {3'h0, ampin_ff, ref_ff, gain_ff};
            ADDR_BGAP:   nxt_rd_data = {7'h00, bgap_ff};
            ADDR_RES_HI: begin
                nxt_rd_data = fmt_ff ? {4'h0, result_ff[11:8]} : result_ff[11:4];
            end
            ADDR_RES_LO: begin
                nxt_rd_data = fmt_ff ? result_ff[7:0] : {result_ff[3:0], 4'h0};
            end
            ADDR_IRQ:    nxt_rd_data = {5'h00, flag_ff, cie_ff, gie_ff};
            ADDR_PIN_LO: nxt_rd_data = pin_ana_ff[7:0];
            ADDR_PIN_HI: nxt_rd_data = pin_ana_ff[15:8];
            default:     nxt_rd_data = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= REG_RST;
        end else begin
            rd_data_ff <= rd_en ? nxt_rd_data : REG_RST;
        end
    end

    adss_src_sel u_sel (
        .ref_src_sel      (ref_ff),
        .amp_input_sel    (ampin_ff),
        .input_source_sel (src_ff),
        .ref_kind         (sel_ref),
        .ext_ref_pin_en   (sel_ext_ref),
        .amp_bandgap_in   (sel_amp_bg),
        .amp_ext_pin_en   (sel_amp_ext),
        .in_kind          (sel_in),
        .ext_chan_en      (sel_ext_en)
    );

    // analog routing and pin overrides
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_kind_ff <= REF_SUPPLY;
            ext_ref_ff  <= BIT_RST;
            amp_bg_ff   <= BIT_RST;
            amp_ext_ff  <= BIT_RST;
            in_kind_ff  <= IN_EXT;
            ext_en_ff   <= BIT_RST;
            ext_chan_ff <= '0;
            sample_ff   <= BIT_RST;
            pull_up_ff  <= '0;
            port_oe_ff  <= '0;
        end else begin
            ref_kind_ff <= sel_ref;
            ext_ref_ff  <= sel_ext_ref;
            amp_bg_ff   <= sel_amp_bg;
            amp_ext_ff  <= sel_amp_ext;
            in_kind_ff  <= sel_in;
            ext_en_ff   <= sel_ext_en;
            ext_chan_ff <= sel_ext_en ? chan_ff : 4'h0;
            sample_ff   <= (state_ff == ST_SAMPLE);
            pull_up_ff  <= pull_up_req & ~pin_ana_ff;
            port_oe_ff  <= port_oe_req & ~pin_ana_ff;
        end
    end

    assign rd_data        = rd_data_ff;
    assign conv_power     = pwr_ff;
    assign bandgap_enable = bgap_ff;
    assign ref_kind       = ref_kind_ff;
    assign ext_ref_pin_en = ext_ref_ff;
    assign amp_bandgap_in = amp_bg_ff;
    assign amp_ext_pin_en = amp_ext_ff;
    assign amp_gain       = gain_ff;
    assign in_kind        = in_kind_ff;
    assign ext_chan_en    = ext_en_ff;
    assign ext_chan       = ext_chan_ff;
    assign sample_on      = sample_ff;
    assign dac_code       = sar_ff;
    assign conv_busy      = busy_ff;
    assign irq            = irq_ff;
    assign pin_analog     = pin_ana_ff;
    assign pull_up_en     = pull_up_ff;
    assign port_oe        = port_oe_ff;

    // checks
    logic [4:0] tk_cnt_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tk_cnt_ff <= '0;
        end else if (launch) begin
            tk_cnt_ff <= '0;
        end else if (busy_ff && tick) begin
            tk_cnt_ff <= tk_cnt_ff + 5'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ref_supply_a: assert property (ref_ff == 2'b00 |=> ref_kind == REF_SUPPLY)
        else $error("supply reference not routed");
    ref_pin_a: assert property (ext_ref_pin_en |-> ref_kind == REF_EXT_PIN)
        else $error("external reference pin on with internal reference");
    amp_in_a: assert property (ampin_ff |=> amp_bandgap_in && !amp_ext_pin_en)
        else $error("amplifier pin not dropped for bandgap");
    gnd_input_a: assert property (src_ff[3:2] == 2'b10 |=> in_kind == IN_GND)
        else $error("reserved source not grounded");
    ext_off_a: assert property (in_kind != IN_EXT |-> !ext_chan_en)
        else $error("external channel left on with internal source");
    pin_over_a: assert property (|(pin_analog & (pull_up_en | port_oe)) == 1'b0)
        else $error("analog pin still has pull-up or drive");
    conv_len_a: assert property (conv_done |-> tk_cnt_ff == TOTAL_CLKS - 5'h1)
        else $error("conversion not sixteen converter clocks");
    launch_busy_a: assert property (launch |=> conv_busy ##1 conv_busy)
        else $error("launch did not raise busy");
    done_end_a: assert property (conv_done |=> !conv_busy && flag_ff)
        else $error("completion did not drop busy and set flag");
    irq_gate_a: assert property (irq |-> $past(gie_ff) && $past(cie_ff))
        else $error("interrupt without both enables");
    nopwr_a: assert property (!pwr_ff |=> !conv_busy)
        else $error("busy while powered down");

    done_c: cover property (conv_done);
    irq_c: cover property ($rose(irq));
    abort_c: cover property (busy_ff && start_rise);
    fmt_c: cover property (conv_done ##[1:20] (rd_en && addr == ADDR_RES_LO && fmt_ff));
endmodule

/* File: core/adss_pkg.sv */
package adss_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RES_W  = 12;
    localparam int CHAN_N = 16;

    localparam logic [3:0] ADDR_CTRL0  = 4'h0;
    localparam logic [3:0] ADDR_CTRL1  = 4'h1;
    localparam logic [3:0] ADDR_CTRL2  = 4'h2;
    localparam logic [3:0] ADDR_BGAP   = 4'h3;
    localparam logic [3:0] ADDR_RES_HI = 4'h4;
    localparam logic [3:0] ADDR_RES_LO = 4'h5;
    localparam logic [3:0] ADDR_IRQ    = 4'h6;
    localparam logic [3:0] ADDR_PIN_LO = 4'h7;
    localparam logic [3:0] ADDR_PIN_HI = 4'h8;

    localparam int C0_START    = 7;
    localparam int C0_BUSY     = 6;
    localparam int C0_PWR      = 5;
    localparam int C0_FMT      = 4;
    localparam int C0_CHAN_LSB = 0;
    localparam int C1_SRC_LSB  = 4;
    localparam int C1_DIV_LSB  = 0;
    localparam int C2_AMPIN    = 4;
    localparam int C2_REF_LSB  = 2;
    localparam int C2_GAIN_LSB = 0;
    localparam int BG_EN       = 0;
    localparam int IRQ_GIE     = 0;
    localparam int IRQ_CIE     = 1;
    localparam int IRQ_FLAG    = 2;

    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic        BIT_RST  = 1'b0;
    localparam logic [11:0] RES_RST  = 12'h000;
    localparam logic [11:0] SAR_INIT = 12'h800;

    localparam logic [3:0] SAMPLE_CLKS = 4'h4;
    localparam logic [3:0] CONV_CLKS   = 4'hc;
    localparam logic [4:0] TOTAL_CLKS  = 5'h10;

    typedef enum logic [1:0] {REF_SUPPLY, REF_EXT_PIN, REF_AMP} adss_ref_t;
    typedef enum logic [2:0] {
        IN_EXT, IN_SUP1, IN_SUP2, IN_SUP4, IN_AMP1, IN_AMP2, IN_AMP4, IN_GND
    } adss_in_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adss_state_t;
endpackage

/* File: core/adss_clk_div.sv */
`timescale 1ns/1ps
module adss_clk_div
    import adss_pkg::*;
#(
    parameter int SEL_W = 3,
    parameter int CNT_W = 7
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             restart,
    input  wire logic [SEL_W-1:0] div_sel,
    output logic                  tick
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] limit;

    // divide by 2**div_sel; select 0 ticks on every edge
    assign limit = CNT_W'((1 << div_sel) - 1);
    assign tick  = (cnt_ff == limit);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (restart || tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    div_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (div_sel == '0) |-> tick)
        else $error("undivided clock missed a tick");
endmodule

/* File: core/adss_src_sel.sv */
`timescale 1ns/1ps
module adss_src_sel
    import adss_pkg::*;
(
    input  wire logic [1:0] ref_src_sel,
    input  wire logic       amp_input_sel,
    input  wire logic [3:0] input_source_sel,
    output adss_ref_t       ref_kind,
    output logic            ext_ref_pin_en,
    output logic            amp_bandgap_in,
    output logic            amp_ext_pin_en,
    output adss_in_t        in_kind,
    output logic            ext_chan_en
);
    always_comb begin
        unique case (ref_src_sel)
            2'b00:        ref_kind = REF_SUPPLY;
            2'b01:        ref_kind = REF_EXT_PIN;
            2'b10, 2'b11: ref_kind = REF_AMP;
        endcase
        // the pin is only connected when no internal reference is chosen
        ext_ref_pin_en = (ref_kind == REF_EXT_PIN);
        amp_bandgap_in = amp_input_sel;
        amp_ext_pin_en = !amp_input_sel;
        unique case (input_source_sel)
            4'b0000, 4'b0100, 4'b1100,
            4'b1101, 4'b1110, 4'b1111: in_kind = IN_EXT;
            4'b0001: in_kind = IN_SUP1;
            4'b0010: in_kind = IN_SUP2;
            4'b0011: in_kind = IN_SUP4;
            4'b0101: in_kind = IN_AMP1;
            4'b0110: in_kind = IN_AMP2;
            4'b0111: in_kind = IN_AMP4;
            4'b1000, 4'b1001,
            4'b1010, 4'b1011: in_kind = IN_GND;
        endcase
        ext_chan_en = (in_kind == IN_EXT);
    end
endmodule

/* File: sim/adss_analog_model.sv */
`timescale 1ns/1ps
module adss_analog_model
    import adss_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [RES_W-1:0] dac_code,
    input  wire logic [RES_W-1:0] level,
    output logic                  cmp_in
);
    // comparator output settles one clock after the trial word moves
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_in <= 1'b0;
        end else begin
            cmp_in <= (level >= dac_code);
        end
    end
endmodule

/* File: sim/adss_top_test.sv */
`timescale 1ns/1ps
module adss_top_test
    import adss_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] pull_up_req = 16'h0000;
    logic [15:0] port_oe_req = 16'h0000;
    logic [11:0] level = 12'h000;
    logic [7:0]  rd_data;
    logic        cmp_in, conv_power, bandgap_enable, ext_ref_pin_en, amp_bandgap_in;
    logic        amp_ext_pin_en, ext_chan_en, sample_on, conv_busy, irq;
    logic [1:0]  amp_gain, gc, r;
    logic [3:0]  ext_chan, ch;
    logic [11:0] dac_code;
    logic [15:0] pin_analog, pull_up_en, port_oe, pv;
    adss_ref_t   ref_kind;
    adss_in_t    in_kind;
    logic        fmt, ai, rd_d = 1'b0;
    logic [7:0]  rd_q[$];
    logic [31:0] seed = 32'h8dcfb1b9;
    int          fails = 0, comparisons = 0, cyc = 0, n;

    adss_top dut (.mclk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cmp_in,
        .pull_up_req, .port_oe_req, .conv_power, .bandgap_enable, .ref_kind,
        .ext_ref_pin_en, .amp_bandgap_in, .amp_ext_pin_en, .amp_gain, .in_kind,
        .ext_chan_en, .ext_chan, .sample_on, .dac_code, .conv_busy, .irq, .pin_analog,
        .pull_up_en, .port_oe);
    adss_analog_model model (.mclk, .rst_n, .dac_code, .level, .cmp_in);

    always #4 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic adss_in_t exp_in(input logic [3:0] s);
        case (s)
            4'h1, 4'h2, 4'h3: return adss_in_t'(s[2:0]);
            4'h5, 4'h6, 4'h7: return adss_in_t'(s[2:0] - 3'h1);
            4'h8, 4'h9, 4'ha, 4'hb: return IN_GND;
            default: return IN_EXT;
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        rd_q.push_back(e);
        @(posedge mclk);
        rd_en <= 1'b0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_d) begin
            chk(16'(rd_data), 16'(rd_q.pop_front()));
        end
        rd_d <= rd_en;
        cyc++;
        if (cyc > 20000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) rd(4'(a), 8'h00);
        rd(4'hf, 8'h00);
        wr(ADDR_BGAP, 8'hff);
        settle(2);
        chk(16'(bandgap_enable), 16'h1);
        rd(ADDR_BGAP, 8'h01);
        wr(ADDR_BGAP, 8'h00);
        settle(2);
        chk(16'(bandgap_enable), 16'h0);
        for (int i = 0; i < 8; i++) begin
            r = 2'(i);
            ai = i[2];
            wr(ADDR_CTRL2, {3'b000, ai, r, 2'b01});
            settle(3);
            chk(16'(ref_kind), (r == 2'b00) ? 16'(REF_SUPPLY) : 16'(r[1] ? REF_AMP : REF_EXT_PIN));
            chk(16'(ext_ref_pin_en), 16'(r == 2'b01));
            chk(16'({amp_bandgap_in, amp_ext_pin_en}), ai ? 16'h2 : 16'h1);
            chk(16'(amp_gain), 16'h1);
        end
        for (int i = 0; i < 16; i++) begin
            ch = 4'(rnd());
            wr(ADDR_CTRL0, {4'h0, ch});
            wr(ADDR_CTRL1, {4'(i), 4'h0});
            settle(3);
            chk(16'(in_kind), 16'(exp_in(4'(i))));
            chk(16'(ext_chan_en), 16'(exp_in(4'(i)) == IN_EXT));
            if (exp_in(4'(i)) == IN_EXT) begin
                chk(16'(ext_chan), 16'(ch));
            end else begin
                chk(16'(ext_chan), 16'h0);
            end
        end
        pv = 16'(rnd());
        wr(ADDR_PIN_LO, pv[7:0]);
        wr(ADDR_PIN_HI, pv[15:8]);
        @(posedge mclk);
        pull_up_req <= 16'(rnd());
        port_oe_req <= 16'(rnd());
        settle(3);
        chk(pin_analog, pv);
        chk(pull_up_en, pull_up_req & ~pv);
        chk(port_oe, port_oe_req & ~pv);
        rd(ADDR_PIN_HI, pv[15:8]);
        wr(ADDR_CTRL2, 8'h00);
        for (int k = 0; k < 3; k++) begin
            gc = (k == 0) ? 2'b11 : 2'(k);
            fmt = k[0];
            @(posedge mclk);
            level <= 12'(rnd());
            wr(ADDR_IRQ, {6'h00, gc});
            wr(ADDR_CTRL1, 8'(k + 2));
            wr(ADDR_CTRL0, {3'b101, fmt, 4'h0});
            wr(ADDR_CTRL0, {3'b001, fmt, 4'h0});
            n = 0;
            while (conv_busy !== 1'b1 && n < 10) begin
                settle(1);
                n++;
            end
            n = 0;
            while (conv_busy === 1'b1 && n < 2000) begin
                settle(1);
                n++;
            end
            chk(16'(n), 16'(16 << (k + 2)));
            settle(2);
            chk(16'(irq), 16'(gc == 2'b11));
            chk(16'(dac_code), 16'(level));
            rd(ADDR_IRQ, {5'h00, 1'b1, gc});
            rd(ADDR_RES_HI, fmt ? {4'h0, level[11:8]} : level[11:4]);
            rd(ADDR_RES_LO, fmt ? level[7:0] : {level[3:0], 4'h0});
            wr(ADDR_IRQ, {6'h00, gc});
            settle(2);
            chk(16'(irq), 16'h0);
        end
        wr(ADDR_CTRL0, 8'h80);
        wr(ADDR_CTRL0, 8'h00);
        settle(4);
        chk(16'({conv_power, conv_busy}), 16'h0);
        wr(ADDR_CTRL0, 8'ha0);
        wr(ADDR_CTRL0, 8'h20);
        settle(10);
        chk(16'({conv_power, conv_busy, sample_on}), 16'h7);
        wr(ADDR_CTRL0, 8'ha0);
        settle(2);
        chk(16'({conv_power, conv_busy}), 16'h2);
        wr(ADDR_CTRL0, 8'h00);
        settle(2);
        chk(16'({conv_power, conv_busy, sample_on}), 16'h0);
        settle(2);
        report_and_stop();
    end
endmodule
